// >>> verilog/watchdog_timer_guard_pkg.sv
package watchdog_timer_guard_pkg;

	// Mode register: fixed top field, stop bit, clock select, overflow select
	localparam logic [7:0] MODE_FIXED_MASK = 8'hE0;
	localparam logic [7:0] MODE_FIXED_PAT = 8'h60;
	localparam logic [7:0] MODE_RESET = 8'h67;
	localparam int STOP_BIT = 4;
	localparam int CLK_SEL_BIT = 3;
	localparam int OVF_SEL_HI = 2;
	localparam int OVF_SEL_LO = 0;

	// Restart register key and fixed read-back value
	localparam logic [7:0] RESTART_KEY = 8'hAC;
	localparam logic [7:0] RESTART_READBACK = 8'h9A;

	// Register selects on the CPU access port
	localparam logic REG_MODE = 1'b0;
	localparam logic REG_RESTART = 1'b1;

	// Counter sizing: overflow select 0 trips at 2**OVF_BASE ticks
	localparam int OVF_BASE = 10;
	localparam int CNT_W_DEFAULT = 18;
	localparam int OVF_SEL_W = OVF_SEL_HI - OVF_SEL_LO + 1;

	// Wait cycles inserted on a mode register write
	localparam int MODE_WAIT_CYCLES = 1;

	typedef enum logic [1:0]
	{
		CFG_OPEN = 2'b00,
		CFG_LOCKED = 2'b01,
		CFG_HALTED = 2'b11
	} cfg_state_t;

endpackage : watchdog_timer_guard_pkg

// >>> verilog/watchdog_timer_guard.sv
`timescale 1ns/1ps
// Overview of operation
// - A mode register write inserts one bus wait cycle; no writes on subsystem clock.
// - Non-stoppable option: differing values in the top three mode bits are ignored.
// - After reset exactly one full-byte write configures the mode register.
// - Any further write attempt to the mode register raises internal reset, except once the stop bit has halted the watchdog.
// - Misuse while source clock stopped: reset is held until the clock resumes.
// - Single-bit accesses cannot set the mode register.
// - Stoppable option: stop bit halts the watchdog for good, no reset on clear.
// - Any restart register byte other than the key raises internal reset.
// - A single-bit access to the restart register raises internal reset.
// - Reading the restart register always returns the fixed read-back value.
// - Non-stoppable option: the watchdog counts always, even in stop mode.
// - Non-stoppable option: overflow in stop mode raises internal reset.
// - Stoppable option: counting is suspended in halt or stop mode.
// - After halt or stop, counting resumes on the previously selected clock.
// - After halt or stop, the counter keeps its count.
module watchdog_timer_guard
#(
	parameter int CNT_W = watchdog_timer_guard_pkg::CNT_W_DEFAULT
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic option_stoppable,
	input wire logic halt_mode,
	input wire logic stop_mode,
	input wire logic src_run,
	input wire logic src_tick_main,
	input wire logic src_tick_alt,
	input wire logic acc_wr,
	input wire logic acc_rd,
	input wire logic acc_sel,
	input wire logic acc_bit_op,
	input wire logic [7:0] acc_wdata,
	output logic [7:0] rd_data,
	output logic bus_wait,
	output logic chip_reset_req,
	output logic wdt_running,
	output watchdog_timer_guard_pkg::cfg_state_t cfg_state
);
	import watchdog_timer_guard_pkg::*;

	// Overflow index must stay inside the counter for every select value
	initial
	begin
		if (CNT_W < OVF_BASE + (1 << OVF_SEL_W))
		begin
			$error("CNT_W too small for the overflow select range");
		end
		if (MODE_WAIT_CYCLES < 1 || MODE_WAIT_CYCLES > 256)
		begin
			$error("MODE_WAIT_CYCLES outside the wait counter range");
		end
		if ((1 << $clog2(CNT_W)) < OVF_BASE + (1 << OVF_SEL_W))
		begin
			$error("Overflow index too narrow for the select range");
		end
	end

	logic [7:0] watchdog_mode_reg;
	logic [CNT_W-1:0] count;
	logic misuse_pend;
	cfg_state_t next_cfg_state;
	logic [7:0] next_mode;

	logic mode_wr;
	logic restart_wr;
	logic mode_accept;
	logic mode_misuse;
	logic restart_misuse;
	logic restart_ok;
	logic misuse_now;
	logic suspend;
	logic src_active;
	logic tick;
	logic count_en;
	logic [OVF_SEL_W-1:0] ovf_sel;
	logic [$clog2(CNT_W)-1:0] ovf_idx;
	logic ovf_hit;
	logic low_power;
	logic stop_req;
	logic tick_sel;
	logic [7:0] wait_left;
	logic [7:0] next_rd_data;
	logic [CNT_W-1:0] next_count;
	logic next_misuse_pend;
	logic next_reset_req;

	assign mode_wr = ce && acc_wr && (acc_sel == REG_MODE);
	assign restart_wr = ce && acc_wr && (acc_sel == REG_RESTART);

	// Only the first full-byte write after reset is taken
	assign mode_accept = mode_wr && !acc_bit_op && (cfg_state == CFG_OPEN);

	// A write of any width after configuration is a misuse
	assign mode_misuse = mode_wr && (cfg_state != CFG_OPEN);

	assign restart_misuse = restart_wr && (acc_bit_op || acc_wdata != RESTART_KEY);
	assign restart_ok = restart_wr && !acc_bit_op && (acc_wdata == RESTART_KEY);

	assign misuse_now = mode_misuse || restart_misuse;

	// Low-power suspend only exists in the stoppable option
	assign low_power = halt_mode || stop_mode;
	assign suspend = option_stoppable && low_power;

	// Stop request only honoured where software may stop the oscillator
	assign stop_req = option_stoppable && acc_wdata[STOP_BIT];

	// Source clock counts as stopped when gated off by software or low power
	assign src_active = src_run && !suspend && (cfg_state != CFG_HALTED);

	// Clock select bit survives low power, so resume uses the same source
	assign tick_sel = watchdog_mode_reg[CLK_SEL_BIT];
	assign tick = tick_sel ? src_tick_alt : src_tick_main;

	assign count_en = ce && src_active && tick;

	assign ovf_sel = watchdog_mode_reg[OVF_SEL_HI:OVF_SEL_LO];
	assign ovf_idx = ($clog2(CNT_W))'(OVF_BASE + int'(ovf_sel));
	assign ovf_hit = count[ovf_idx];

	// Stored mode value for the accepted write
	always_comb
	begin
		next_mode = acc_wdata;
		if (!option_stoppable)
		begin
			next_mode = (acc_wdata & ~MODE_FIXED_MASK) | MODE_FIXED_PAT;
		end
	end

	// Configuration state; a halted watchdog never comes back
	always_comb
	begin
		next_cfg_state = cfg_state;
		case (cfg_state)
			CFG_OPEN:
			begin
				if (mode_accept)
				begin
					if (stop_req)
					begin
						next_cfg_state = CFG_HALTED;
					end
					else
					begin
						next_cfg_state = CFG_LOCKED;
					end
				end
			end
			CFG_LOCKED:
			begin
				next_cfg_state = CFG_LOCKED;
			end
			CFG_HALTED:
			begin
				// Clearing the stop bit is impossible and would not restart
				next_cfg_state = CFG_HALTED;
			end
			default:
			begin
				next_cfg_state = CFG_OPEN;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cfg_state <= CFG_OPEN;
		end
		else if (ce)
		begin
			cfg_state <= next_cfg_state;
		end
	end

	// Write-once mode register
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			watchdog_mode_reg <= MODE_RESET;
		end
		else if (mode_accept)
		begin
			watchdog_mode_reg <= next_mode;
		end
	end

	// Wait stretcher on every mode register write; counted so a slower bus can widen it
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wait_left <= 8'h00;
			bus_wait <= 1'b0;
		end
		else if (ce)
		begin
			if (mode_wr)
			begin
				wait_left <= 8'(MODE_WAIT_CYCLES - 1);
				bus_wait <= 1'b1;
			end
			else if (wait_left != 8'h00)
			begin
				wait_left <= wait_left - 8'h01;
				bus_wait <= 1'b1;
			end
			else
			begin
				bus_wait <= 1'b0;
			end
		end
	end

	// Read data holds between reads
	always_comb
	begin
		next_rd_data = rd_data;
		if (acc_rd)
		begin
			case (acc_sel)
				REG_RESTART:
				begin
					next_rd_data = RESTART_READBACK;
				end
				default:
				begin
					next_rd_data = watchdog_mode_reg;
				end
			endcase
		end
	end

	// Read data; the restart register never echoes the key
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			rd_data <= 8'h00;
		end
		else if (ce)
		begin
			rd_data <= next_rd_data;
		end
	end

	// Restart beats a tick in the same cycle, so a late key still buys a full interval
	always_comb
	begin
		next_count = count;
		if (restart_ok)
		begin
			next_count = '0;
		end
		else if (count_en && !ovf_hit)
		begin
			next_count = count + 1'b1;
		end
	end

	// Counter holds while suspended instead of clearing
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			count <= '0;
		end
		else if (ce)
		begin
			count <= next_count;
		end
	end

	// Pending misuse is never dropped; only chip reset clears it
	always_comb
	begin
		next_misuse_pend = misuse_pend;
		if (misuse_now)
		begin
			next_misuse_pend = 1'b1;
		end
	end

	// Misuse seen while the source is stopped waits here
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			misuse_pend <= 1'b0;
		end
		else if (ce)
		begin
			misuse_pend <= next_misuse_pend;
		end
	end

	// Causes fire only while the source runs; a stopped source defers them
	always_comb
	begin
		next_reset_req = chip_reset_req;
		if ((misuse_now || misuse_pend) && src_active)
		begin
			next_reset_req = 1'b1;
		end
		if (ovf_hit && src_active)
		begin
			next_reset_req = 1'b1;
		end
	end

	// Internal reset request stays up until the chip reset clears it
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			chip_reset_req <= 1'b0;
		end
		else if (ce)
		begin
			chip_reset_req <= next_reset_req;
		end
	end

	// Running status for software visibility
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wdt_running <= 1'b0;
		end
		else if (ce)
		begin
			wdt_running <= src_active;
		end
	end

endmodule : watchdog_timer_guard

// >>> bench/cpu_model.sv
`timescale 1ns/1ps
module cpu_model
(
	input wire logic clock,
	output logic acc_wr,
	output logic acc_rd,
	output logic acc_sel,
	output logic acc_bit_op,
	output logic [7:0] acc_wdata
);
	initial {acc_wr, acc_rd, acc_sel, acc_bit_op, acc_wdata} = '0;
	// One access, held for one edge
	task acc(input logic wr, input logic sel, input logic bo, input logic [7:0] d);
		@(posedge clock);
		acc_wr <= wr;
		acc_rd <= !wr;
		acc_sel <= sel;
		acc_bit_op <= bo;
		acc_wdata <= d;
		@(posedge clock);
		acc_wr <= 1'b0;
		acc_rd <= 1'b0;
		acc_wdata <= ~d; // Stale data never left on the bus
	endtask : acc
endmodule : cpu_model

// >>> bench/watchdog_timer_guard_monitor.sv
`timescale 1ns/1ps
module watchdog_timer_guard_monitor
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic option_stoppable,
	input wire logic halt_mode,
	input wire logic stop_mode,
	input wire logic src_run,
	input wire logic acc_wr,
	input wire logic acc_rd,
	input wire logic acc_sel,
	input wire logic acc_bit_op,
	input wire logic [7:0] acc_wdata,
	input wire logic [7:0] rd_data,
	input wire logic bus_wait,
	input wire logic chip_reset_req,
	input wire logic wdt_running,
	input wire watchdog_timer_guard_pkg::cfg_state_t cfg_state
);
	import watchdog_timer_guard_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire logic mw = ce && acc_wr && acc_sel == REG_MODE;
	wire logic rw = ce && acc_wr && acc_sel == REG_RESTART;
	property p_wait; mw |=> bus_wait; endproperty
	a_wait: assert property (p_wait) else $error("no wait");
	property p_rdb; ce && acc_rd && acc_sel |=> rd_data == RESTART_READBACK; endproperty
	a_rdb: assert property (p_rdb) else $error("bad readback");
	property p_once; mw && !acc_bit_op && cfg_state == CFG_OPEN |=> cfg_state != CFG_OPEN;
	endproperty
	a_once: assert property (p_once) else $error("not locked");
	property p_bit; mw && acc_bit_op && cfg_state == CFG_OPEN |=> cfg_state == CFG_OPEN;
	endproperty
	a_bit: assert property (p_bit) else $error("bit op set mode");
	wire logic sus = option_stoppable && (halt_mode || stop_mode);
	property p_twice; mw && cfg_state == CFG_LOCKED && wdt_running && src_run && !sus
		|-> ##[1:2] chip_reset_req; endproperty
	a_twice: assert property (p_twice) else $error("no reset");
	property p_key; rw && (acc_bit_op || acc_wdata != RESTART_KEY) && wdt_running && src_run
		&& !sus |-> ##[1:2] chip_reset_req; endproperty
	a_key: assert property (p_key) else $error("no key reset");
	property p_hold; rw && (acc_bit_op || acc_wdata != RESTART_KEY) && !src_run
		&& !chip_reset_req |=> !chip_reset_req; endproperty
	a_hold: assert property (p_hold) else $error("reset not held off");
	property p_susp; ce && option_stoppable && (halt_mode || stop_mode) |=> !wdt_running;
	endproperty
	a_susp: assert property (p_susp) else $error("not suspended");
	property p_keep; ce && !option_stoppable && src_run |=> wdt_running; endproperty
	a_keep: assert property (p_keep) else $error("stopped");
	c_rst: cover property (chip_reset_req);
	c_halt: cover property (cfg_state == CFG_HALTED);
	c_wait: cover property (bus_wait);
endmodule : watchdog_timer_guard_monitor
bind watchdog_timer_guard watchdog_timer_guard_monitor mon_u (.clock, .rst, .ce,
	.option_stoppable, .halt_mode, .stop_mode, .src_run, .acc_wr, .acc_rd, .acc_sel,
	.acc_bit_op, .acc_wdata, .rd_data, .bus_wait, .chip_reset_req, .wdt_running, .cfg_state);

// >>> bench/watchdog_timer_guard_tb.sv
`timescale 1ns/1ps
module watchdog_timer_guard_tb;
	import watchdog_timer_guard_pkg::*;
	logic clock = 0, rst = 1, ce = 1, opt = 0, halt = 0, stp = 0, run = 1, tick = 0, alt = 0;
	logic acc_wr, acc_rd, acc_sel, acc_bit_op, bus_wait, req, running;
	logic [7:0] acc_wdata, rd_data, d;
	cfg_state_t cfg;
	int num_errors = 0, checked = 0, cyc = 0;
	always #25 clock = ~clock;
	watchdog_timer_guard dut_u (.clock, .rst, .ce, .option_stoppable(opt), .halt_mode(halt),
		.stop_mode(stp), .src_run(run), .src_tick_main(tick), .src_tick_alt(alt), .acc_wr,
		.acc_rd, .acc_sel, .acc_bit_op, .acc_wdata, .rd_data, .bus_wait,
		.chip_reset_req(req), .wdt_running(running), .cfg_state(cfg));
	cpu_model cpu_u (.clock, .acc_wr, .acc_rd, .acc_sel, .acc_bit_op, .acc_wdata);
	task give_verdict;
		$display("checked %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask : chk
	task go(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : go
	// Reset is sticky, so each misuse case needs a fresh start
	task restart(input logic o);
		@(posedge clock);
		{rst, opt, halt, stp, run, tick, alt} <= {1'b1, o, 5'b00100};
		repeat (4) @(posedge clock);
		rst <= 1'b0;
	endtask : restart
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			give_verdict();
		end
	end
	initial
	begin
		void'($urandom(85261));
		restart(1'b0);
		cpu_u.acc(1'b0, REG_RESTART, 1'b0, 8'h00);
		#1 chk("readback", rd_data, RESTART_READBACK);
		ce <= 1'b0;
		cpu_u.acc(1'b1, REG_MODE, 1'b0, 8'h60);
		ce <= 1'b1;
		#1 chk("frozen", 8'(cfg), 8'(CFG_OPEN));
		cpu_u.acc(1'b1, REG_MODE, 1'b1, 8'h60);
		#1 chk("bit op", 8'(cfg), 8'(CFG_OPEN));
		cpu_u.acc(1'b1, REG_MODE, 1'b0, 8'hF0); // Upper bits ignored
		#1 chk("wait", 8'(bus_wait), 8'h01);
		chk("lock", 8'(cfg), 8'(CFG_LOCKED));
		cpu_u.acc(1'b0, REG_MODE, 1'b0, 8'h00);
		#1 chk("mode", rd_data, 8'h70);
		{tick, stp} <= 2'b11;
		go(1000);
		chk("run", 8'(running), 8'h01);
		cpu_u.acc(1'b1, REG_RESTART, 1'b0, RESTART_KEY);
		go(1000);
		chk("early", 8'(req), 8'h00);
		go(40);
		chk("overflow", 8'(req), 8'h01);
		$display("test counter done");
		restart(1'b0);
		cpu_u.acc(1'b1, REG_MODE, 1'b0, 8'h63);
		cpu_u.acc(1'b1, REG_MODE, 1'b0, 8'h63);
		go(2);
		chk("second", 8'(req), 8'h01);
		for (int i = 0; i < 2; i++)
		begin
			restart(1'b0);
			d = 8'($urandom) | 8'h01;
			cpu_u.acc(1'b1, REG_RESTART, i[0], i[0] ? RESTART_KEY : d);
			go(2);
			chk("bad key", 8'(req), 8'h01);
		end
		$display("test misuse done");
		restart(1'b0);
		run <= 1'b0;
		cpu_u.acc(1'b1, REG_RESTART, 1'b0, 8'h00);
		go(3);
		chk("held", 8'(req), 8'h00);
		run <= 1'b1;
		go(3);
		chk("late", 8'(req), 8'h01);
		$display("test source done");
		restart(1'b1);
		halt <= 1'b1;
		go(3);
		chk("halt", 8'(running), 8'h00);
		halt <= 1'b0;
		go(3);
		chk("resume", 8'(running), 8'h01);
		// Alternate source, overflow after 1024 ticks; halt in the middle
		cpu_u.acc(1'b1, REG_MODE, 1'b0, 8'h68);
		{tick, alt} <= 2'b01;
		go(600);
		halt <= 1'b1;
		go(100);
		chk("hold", 8'(running), 8'h00);
		halt <= 1'b0;
		go(400);
		chk("kept", 8'(req), 8'h00);
		go(40);
		chk("resumed", 8'(req), 8'h01);
		$display("test low power done");
		restart(1'b1);
		cpu_u.acc(1'b1, REG_MODE, 1'b0, 8'h73);
		cpu_u.acc(1'b1, REG_MODE, 1'b0, 8'h63);
		go(3);
		chk("stopped", {cfg, running, req}, {CFG_HALTED, 2'b00});
		$display("tests done");
		give_verdict();
	end
endmodule : watchdog_timer_guard_tb
